// *** include/fpsm_regs.svh ***
// Register offsets, field positions and reset values of the fan PWM source mux
`ifndef FPSM_REGS_SVH
`define FPSM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FPSM_ADDR_DUTY1      8'h30
`define FPSM_ADDR_DUTY2      8'h31
`define FPSM_ADDR_DUTY3      8'h32
`define FPSM_ADDR_CFG1       8'h5c
`define FPSM_ADDR_CFG2       8'h5d
`define FPSM_ADDR_CFG3       8'h5e
`define FPSM_ADDR_TREE_TEST  8'h6f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPSM_BHV_MSB         7
`define FPSM_BHV_LSB         5
`define FPSM_TREE_EN_BIT     0

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define FPSM_CFG_RESET       8'h82
`define FPSM_TREE_RESET      8'h00
`define FPSM_DUTY_RESET      8'h00
`define FPSM_DUTY_FULL       8'hff
`define FPSM_DUTY_OFF        8'h00
`define FPSM_TIMER_MAX       16'hffff
`define FPSM_READ_ZERO       8'h00

`endif

// *** include/fpsm_pkg.sv ***
// Types and shared arithmetic of the fan PWM source mux
package fpsm_pkg;

    // ----------------------------------------
    // Behaviour-select codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        BHV_REMOTE1 = 3'h0,
        BHV_LOCAL   = 3'h1,
        BHV_REMOTE2 = 3'h2,
        BHV_FULL    = 3'h3,
        BHV_OFF     = 3'h4,
        BHV_MAX_LR2 = 3'h5,
        BHV_MAX_ALL = 3'h6,
        BHV_MANUAL  = 3'h7
    } fpsm_behaviour_t;

    typedef logic [7:0] fpsm_duty_t;

    // ----------------------------------------
    // Larger of two duty values
    // ----------------------------------------
    function automatic fpsm_duty_t fpsm_max(input fpsm_duty_t a, input fpsm_duty_t b);
        fpsm_max = (a > b) ? a : b;
    endfunction

endpackage

// *** logic/fpsm_duty_store.sv ***
// Three-word duty store with per-word write ports and a registered read port
`timescale 1ns/1ps
`include "fpsm_regs.svh"
module fpsm_duty_store (
    input  wire logic        sys_clk,  // System clock
    input  wire logic        rst_n,    // Async reset, active low
    input  wire logic [2:0]  we,       // Write enable per word
    input  wire logic [23:0] wdata,    // Write data, word 0 in low byte
    input  wire logic [1:0]  raddr,    // Read word index
    output logic      [7:0]  rdata,    // Registered read data
    output logic      [23:0] q         // Current contents, word 0 in low byte
);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Full from reset, so no output dips low in the first cycle after release
            q <= {3{`FPSM_DUTY_FULL}};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (we[i]) begin
                    q[i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `FPSM_DUTY_RESET;
        end else begin
            unique case (raddr)
                2'h0:    rdata <= q[7:0];
                2'h1:    rdata <= q[15:8];
                2'h2:    rdata <= q[23:16];
                default: rdata <= `FPSM_READ_ZERO;
            endcase
        end
    end

endmodule

// *** logic/fpsm_top.sv ***
// Fan PWM source mux: per-output duty routing, standby reaction and test-mode entry
//
// How it works
// - Core supply below limit sets status flag
// - Undervoltage drives alert only when enabled
// - Standby suspends thermal pin; timer holds value
// - Supply back above limit resumes everything
// - Test register bit 0 enters tree test
// - After reset outputs run full; supply watch runs, timer waits for monitor_enable
// - Each output has its own behaviour field
// - Codes 000/001/010 pick one channel duty
// - Code 101 takes faster of local, remote2
// - Code 110 takes fastest of all three
// - Code 011 forces full speed
// - Code 100 disables output; reset value
// - Code 111 makes duty register software-driven
// - Any output may follow any channel
// - Automatic routing starts at the first config write, then runs without software action
// - Duty is eight bits, zero to full
// - Duty register reads back the applied duty
`timescale 1ns/1ps
`include "fpsm_regs.svh"
module fpsm_top (
    input  wire logic        sys_clk,               // System clock, 100 MHz
    input  wire logic        rst_n,                 // Async reset, active low
    input  wire logic [7:0]  reg_addr,              // Register address
    input  wire logic [7:0]  reg_wdata,             // Register write data
    input  wire logic        reg_wr,                // Register write strobe
    input  wire logic        reg_rd,                // Register read strobe
    output logic      [7:0]  reg_rdata,             // Register read data
    output logic             reg_rvalid,            // Read data valid pulse
    input  wire logic [7:0]  core_supply_voltage,   // Core supply reading
    input  wire logic [7:0]  core_supply_low_limit, // Core supply low limit
    input  wire logic        supply_alert_enable,   // Alert source enable
    input  wire logic        monitor_enable,        // Monitoring switched on
    input  wire logic        status_clear,          // Clear pulse for the flag
    input  wire logic [7:0]  duty_remote1,          // Computed duty, remote channel one
    input  wire logic [7:0]  duty_local,            // Computed duty, local channel
    input  wire logic [7:0]  duty_remote2,          // Computed duty, remote channel two
    input  wire logic        thermal_pin_n,         // Thermal pin, asynchronous
    output logic             core_supply_flag,      // Sticky undervoltage flag
    output logic             smbalert_o,            // Alert pin output level
    output logic             smbalert_oe_n,         // Alert pin enable, low drives
    output logic             standby_active,        // Supply below limit
    output logic      [15:0] thermal_timer,         // Thermal pin accumulation timer
    output logic             tree_test_mode,        // Tree test mode active
    output logic      [2:0]  pwm_out                // PWM waveforms
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [7:0]  cfg [3];
    logic [2:0]  cfg_written;
    logic [7:0]  tree_reg;
    logic [23:0] duty_q;
    logic [23:0] next_duty;
    logic [2:0]  duty_we;
    logic [7:0]  store_rdata;
    logic [1:0]  rd_index;
    logic [1:0]  rd_stage;
    logic [7:0]  rd_hold;
    logic        rd_from_store;
    logic        thermal_meta;
    logic        thermal_sync_n;
    logic [7:0]  pwm_cnt;
    logic        supply_below;
    logic        next_flag;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [2:0] bhv_of(input logic [7:0] c);
        bhv_of = c[`FPSM_BHV_MSB:`FPSM_BHV_LSB];
    endfunction

    function automatic logic duty_hit(input logic [7:0] a, input int i);
        duty_hit = (a == (`FPSM_ADDR_DUTY1 + 8'(i)));
    endfunction

    function automatic logic cfg_hit(input logic [7:0] a, input int i);
        cfg_hit = (a == (`FPSM_ADDR_CFG1 + 8'(i)));
    endfunction

    // ----------------------------------------
    // Configuration and test registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                cfg[i] <= `FPSM_CFG_RESET;
            end
            cfg_written <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (reg_wr && cfg_hit(reg_addr, i)) begin
                    cfg[i]         <= reg_wdata;
                    cfg_written[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tree_reg       <= `FPSM_TREE_RESET;
            tree_test_mode <= 1'b0;
        end else if (reg_wr && reg_addr == `FPSM_ADDR_TREE_TEST) begin
            tree_reg       <= reg_wdata;
            tree_test_mode <= reg_wdata[`FPSM_TREE_EN_BIT];
        end
    end

    // ----------------------------------------
    // Duty routing
    // ----------------------------------------
    // Until software has touched an output's config it runs full, so fans are
    // never left stopped while the host is still booting.
    always_comb begin
        next_duty = duty_q;
        duty_we   = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (!cfg_written[i]) begin
                next_duty[i*8 +: 8] = `FPSM_DUTY_FULL;
                duty_we[i]          = 1'b1;
            end else begin
                duty_we[i] = 1'b1;
                unique case (fpsm_pkg::fpsm_behaviour_t'(bhv_of(cfg[i])))
                    fpsm_pkg::BHV_REMOTE1: next_duty[i*8 +: 8] = duty_remote1;
                    fpsm_pkg::BHV_LOCAL:   next_duty[i*8 +: 8] = duty_local;
                    fpsm_pkg::BHV_REMOTE2: next_duty[i*8 +: 8] = duty_remote2;
                    fpsm_pkg::BHV_FULL:    next_duty[i*8 +: 8] = `FPSM_DUTY_FULL;
                    fpsm_pkg::BHV_OFF:     next_duty[i*8 +: 8] = `FPSM_DUTY_OFF;
                    fpsm_pkg::BHV_MAX_LR2: begin
                        next_duty[i*8 +: 8] = fpsm_pkg::fpsm_max(duty_local, duty_remote2);
                    end
                    fpsm_pkg::BHV_MAX_ALL: begin
                        next_duty[i*8 +: 8] = fpsm_pkg::fpsm_max(duty_remote1,
                            fpsm_pkg::fpsm_max(duty_local, duty_remote2));
                    end
                    fpsm_pkg::BHV_MANUAL:  begin
                        // Host writes land only here; elsewhere they are dropped
                        duty_we[i]          = reg_wr && duty_hit(reg_addr, i);
                        next_duty[i*8 +: 8] = reg_wdata;
                    end
                endcase
            end
        end
    end

    fpsm_duty_store u_duty_store (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .we      (duty_we),
        .wdata   (next_duty),
        .raddr   (rd_index),
        .rdata   (store_rdata),
        .q       (duty_q)
    );

    // ----------------------------------------
    // PWM waveform
    // ----------------------------------------
    // A count of 255 must give a steady high, so full duty is special-cased.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cnt <= 8'h00;
            pwm_out <= 3'h7;
        end else begin
            pwm_cnt <= pwm_cnt + 8'h01;
            for (int i = 0; i < 3; i++) begin
                pwm_out[i] <= (duty_q[i*8 +: 8] == `FPSM_DUTY_FULL) || (pwm_cnt < duty_q[i*8 +: 8]);
            end
        end
    end

    // ----------------------------------------
    // Register read path
    // ----------------------------------------
    // Two cycles: the store answers from its own register, then the mux is
    // registered so reg_rdata leaves straight from a flop.
    always_comb begin
        rd_index = 2'h3;
        for (int i = 0; i < 3; i++) begin
            if (duty_hit(reg_addr, i)) begin
                rd_index = 2'(i);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_stage      <= 2'h0;
            rd_hold       <= `FPSM_READ_ZERO;
            rd_from_store <= 1'b0;
            reg_rdata     <= `FPSM_READ_ZERO;
            reg_rvalid    <= 1'b0;
        end else begin
            rd_stage      <= {rd_stage[0], reg_rd};
            rd_from_store <= (rd_index != 2'h3);
            if (cfg_hit(reg_addr, 0)) begin
                rd_hold <= cfg[0];
            end else if (cfg_hit(reg_addr, 1)) begin
                rd_hold <= cfg[1];
            end else if (cfg_hit(reg_addr, 2)) begin
                rd_hold <= cfg[2];
            end else if (reg_addr == `FPSM_ADDR_TREE_TEST) begin
                rd_hold <= tree_reg;
            end else begin
                rd_hold <= `FPSM_READ_ZERO;
            end
            reg_rvalid <= rd_stage[0];
            if (rd_stage[0]) begin
                reg_rdata <= rd_from_store ? store_rdata : rd_hold;
            end
        end
    end

    // ----------------------------------------
    // Core supply watch and alert
    // ----------------------------------------
    assign supply_below = core_supply_voltage < core_supply_low_limit;
    // Set wins over clear so an undervoltage in the clear cycle is kept
    assign next_flag    = supply_below || (core_supply_flag && !status_clear);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_supply_flag <= 1'b0;
            standby_active   <= 1'b0;
            smbalert_o       <= 1'b0;
            smbalert_oe_n    <= 1'b1;
        end else begin
            core_supply_flag <= next_flag;
            standby_active   <= supply_below;
            smbalert_o       <= 1'b0;
            smbalert_oe_n    <= !(next_flag && supply_alert_enable);
        end
    end

    // ----------------------------------------
    // Thermal pin timer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_meta   <= 1'b1;
            thermal_sync_n <= 1'b1;
        end else begin
            thermal_meta   <= thermal_pin_n;
            thermal_sync_n <= thermal_meta;
        end
    end

    // Limitation: the timer saturates instead of wrapping
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermal_timer <= 16'h0000;
        end else if (!standby_active && monitor_enable && !thermal_sync_n
                     && thermal_timer != `FPSM_TIMER_MAX) begin
            thermal_timer <= thermal_timer + 16'h0001;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_flag_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        supply_below |=> core_supply_flag)
        else $error("flag not set on undervoltage");

    chk_alert_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !smbalert_oe_n |-> $past(supply_alert_enable) && core_supply_flag)
        else $error("alert driven without enable or flag");

    chk_timer_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        standby_active |=> $stable(thermal_timer))
        else $error("thermal timer moved in standby");

    chk_supply_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !supply_below ##1 !supply_below |-> !standby_active)
        else $error("standby held after supply recovered");

    chk_tree_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && reg_addr == `FPSM_ADDR_TREE_TEST |=> tree_test_mode == $past(reg_wdata[0]))
        else $error("tree test mode not following enable bit");

    chk_boot_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !cfg_written[0] ##1 !cfg_written[0] |-> duty_q[7:0] == `FPSM_DUTY_FULL)
        else $error("output not full before configuration");

    chk_full_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_written[0] && bhv_of(cfg[0]) == 3'h3 |=> duty_q[7:0] == `FPSM_DUTY_FULL)
        else $error("full code not giving full duty");

    chk_off_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_written[1] && bhv_of(cfg[1]) == 3'h4 |=> duty_q[15:8] == `FPSM_DUTY_OFF)
        else $error("disabled output has nonzero duty");

    chk_fastest_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_written[2] && bhv_of(cfg[2]) == 3'h6 |=> duty_q[23:16] >= $past(duty_remote1)
            && duty_q[23:16] >= $past(duty_local) && duty_q[23:16] >= $past(duty_remote2))
        else $error("fastest option below a channel duty");

    chk_manual_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_written[0] && bhv_of(cfg[0]) == 3'h7 && !(reg_wr && reg_addr == `FPSM_ADDR_DUTY1)
            |=> $stable(duty_q[7:0]))
        else $error("manual duty changed without a write");

    chk_read_latency: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd |-> ##2 reg_rvalid)
        else $error("read answer not two cycles later");

endmodule

// *** verif/fpsm_fan_model.sv ***
// Fan side model: measures PWM high time per 256-cycle window and resolves the alert wire
`timescale 1ns/1ps
module fpsm_fan_model (
    input  wire logic        sys_clk,       // System clock
    input  wire logic        rst_n,         // Async reset, active low
    input  wire logic [2:0]  pwm_out,       // PWM waveforms from the block
    input  wire logic        smbalert_o,    // Alert level driven
    input  wire logic        smbalert_oe_n, // Alert enable, low drives
    output logic             alert_line,    // Alert wire with pull-up
    output logic      [26:0] fan_high       // High counts of last window, 9 bits per fan
);
    logic [7:0]  win;
    logic [26:0] acc;

    // Released open-drain line goes to the pull-up level
    assign alert_line = (smbalert_oe_n === 1'b0) ? smbalert_o : 1'b1;

    // Window not aligned to the block's counter: any 256 cycles hold exactly duty high cycles, or 256 at full duty
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            win <= 8'h00;
            acc <= '0;
            fan_high <= '0;
        end else begin
            win <= win + 8'h01;
            for (int i = 0; i < 3; i++) begin
                acc[i*9 +: 9] <= (win == 8'hff) ? 9'h000 : acc[i*9 +: 9] + {8'h00, pwm_out[i]};
                if (win == 8'hff)
                    fan_high[i*9 +: 9] <= acc[i*9 +: 9] + {8'h00, pwm_out[i]};
            end
        end
    end
endmodule

// *** verif/tb_top.sv ***
// Self-checking testbench of the fan PWM source mux
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid;
    logic [7:0]  core_supply_voltage = 8'hc0;
    logic        supply_alert_enable = 1'b1;
    logic        monitor_enable = 1'b0;
    logic        status_clear = 1'b0;
    logic [7:0]  duty_remote1 = 8'h00;
    logic [7:0]  duty_local = 8'h00;
    logic [7:0]  duty_remote2 = 8'h00;
    logic        thermal_pin_n = 1'b1;
    logic        core_supply_flag;
    logic        smbalert_o;
    logic        smbalert_oe_n;
    logic        standby_active;
    logic [15:0] thermal_timer;
    logic        tree_test_mode;
    logic [2:0]  pwm_out;
    logic        alert_line;
    logic [26:0] fan_high;
    logic [7:0]  exp_q[$];
    logic [7:0]  e;
    logic [7:0]  d;
    logic [7:0]  cur[3];
    logic [15:0] t0;
    int          checks = 0;
    int          mismatches = 0;

    always #5 sys_clk = ~sys_clk;

    fpsm_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .core_supply_voltage(core_supply_voltage), .core_supply_low_limit(8'h80),
        .supply_alert_enable(supply_alert_enable), .monitor_enable(monitor_enable),
        .status_clear(status_clear), .duty_remote1(duty_remote1), .duty_local(duty_local),
        .duty_remote2(duty_remote2), .thermal_pin_n(thermal_pin_n), .core_supply_flag(core_supply_flag),
        .smbalert_o(smbalert_o), .smbalert_oe_n(smbalert_oe_n), .standby_active(standby_active),
        .thermal_timer(thermal_timer), .tree_test_mode(tree_test_mode), .pwm_out(pwm_out));

    fpsm_fan_model i_fans (.sys_clk(sys_clk), .rst_n(rst_n), .pwm_out(pwm_out), .smbalert_o(smbalert_o),
        .smbalert_oe_n(smbalert_oe_n), .alert_line(alert_line), .fan_high(fan_high));

    // ----------------------------------------
    // Bus tasks and expectations
    // ----------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        cyc(1);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        cyc(1);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(v);
        cyc(1);
        reg_rd = 1'b0;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_idle;
        for (int i = 0; i < 20 && exp_q.size() != 0; i++)
            cyc(1);
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("BAD read answers exp 0 got %0d", exp_q.size());
            stop_test();
        end
    endtask

    // Fans need two whole windows after a duty change
    task automatic fan_chk(input int o, input logic [7:0] v);
        cyc(520);
        `CHK("fan_high", (v == 8'hff) ? 9'h100 : {1'b0, v}, fan_high[o*9 +: 9]);
    endtask

    function automatic logic [7:0] route(input logic [2:0] c, input logic [7:0] prev);
        logic [7:0] lr;
        logic [7:0] al;
        lr = (duty_local > duty_remote2) ? duty_local : duty_remote2;
        al = (lr > duty_remote1) ? lr : duty_remote1;
        case (c)
            3'h0: route = duty_remote1;
            3'h1: route = duty_local;
            3'h2: route = duty_remote2;
            3'h3: route = 8'hff;
            3'h4: route = 8'h00;
            3'h5: route = lr;
            3'h6: route = al;
            default: route = prev;
        endcase
    endfunction

    always @(posedge sys_clk) begin
        if (reg_rvalid === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
            `CHK("reg_rdata", e, reg_rdata);
        end
    end

    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        $display("BAD run length exp done got timeout");
        stop_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(93));
        cyc(10);
        `CHK("pwm_out", 3'b111, pwm_out);
        rst_n = 1'b1;
        for (int o = 0; o < 3; o++) begin
            rd(8'(8'h5c + o), 8'h82);
            rd(8'(8'h30 + o), 8'hff);
            cur[o] = 8'hff;
        end
        rd(8'h6f, 8'h00);
        wr(8'h41, 8'h5a);
        rd(8'h41, 8'h00);
        wr(8'h30, 8'h55);
        rd(8'h30, 8'hff);
        fan_chk(0, 8'hff);
        fan_chk(2, 8'hff);
        // Host configures every code on every output
        for (int o = 0; o < 3; o++) begin
            for (int c = 0; c < 8; c++) begin
                duty_remote1 = 8'($urandom);
                duty_local = 8'($urandom);
                duty_remote2 = 8'($urandom);
                wr(8'(8'h5c + o), {c[2:0], 5'h02});
                cur[o] = route(c[2:0], cur[o]);
                d = 8'($urandom);
                wr(8'(8'h30 + o), d);
                if (c == 7)
                    cur[o] = d;
                rd(8'(8'h5c + o), {c[2:0], 5'h02});
                rd(8'(8'h30 + o), cur[o]);
                fan_chk(o, cur[o]);
            end
        end
        for (int o = 0; o < 3; o++)
            wr(8'(8'h5c + o), 8'h02);
        for (int o = 0; o < 3; o++)
            rd(8'(8'h30 + o), duty_remote1);
        duty_remote1 = ~duty_remote1;
        cyc(3);
        rd(8'h30, duty_remote1);
        rd(8'h32, duty_remote1);
        wr(8'h6f, 8'h01);
        cyc(2);
        `CHK("tree_test_mode", 1'b1, tree_test_mode);
        rd(8'h6f, 8'h01);
        wr(8'h6f, 8'hfe);
        cyc(2);
        `CHK("tree_test_mode", 1'b0, tree_test_mode);
        rd(8'h6f, 8'hfe);
        wait_idle();
        // Standby reaction
        monitor_enable = 1'b1;
        thermal_pin_n = 1'b0;
        cyc(20);
        `CHK("timer_runs", 1'b1, thermal_timer > 16'h0000);
        core_supply_voltage = 8'h40;
        cyc(2);
        `CHK("core_supply_flag", 1'b1, core_supply_flag);
        `CHK("standby_active", 1'b1, standby_active);
        `CHK("alert_line", 1'b0, alert_line);
        t0 = thermal_timer;
        cyc(20);
        `CHK("thermal_timer", t0, thermal_timer);
        core_supply_voltage = 8'hc0;
        cyc(2);
        `CHK("standby_active", 1'b0, standby_active);
        cyc(10);
        `CHK("timer_resumes", 1'b1, thermal_timer > t0);
        `CHK("core_supply_flag", 1'b1, core_supply_flag);
        status_clear = 1'b1;
        cyc(1);
        status_clear = 1'b0;
        cyc(1);
        `CHK("core_supply_flag", 1'b0, core_supply_flag);
        `CHK("alert_line", 1'b1, alert_line);
        supply_alert_enable = 1'b0;
        core_supply_voltage = 8'h7f;
        cyc(3);
        `CHK("core_supply_flag", 1'b1, core_supply_flag);
        `CHK("alert_line", 1'b1, alert_line);
        // Second reset in mid-run
        rst_n = 1'b0;
        cyc(2);
        `CHK("pwm_out", 3'b111, pwm_out);
        `CHK("core_supply_flag", 1'b0, core_supply_flag);
        rst_n = 1'b1;
        core_supply_voltage = 8'hc0;
        cyc(2);
        rd(8'h5e, 8'h82);
        rd(8'h31, 8'hff);
        wait_idle();
        stop_test();
    end
endmodule
